// ==== rtl/wks_device.sv ====
/*
  Device end: challenge, unlock key sequencer, monitor select and sticky
  self-test result registers.
  Assumes a host on the link keeping the key order; test fail strobes and
  challenge loads arrive synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "wks_consts.svh"
module wks_device
  import wks_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  wks_if.dev              bus,
  input  wire logic [7:0] main_fail_i,
  input  wire logic [3:0] sensor_fail_i,
  output logic            flash_mode_o,
  output logic            config_mode_o,
  output logic            wd_restart_o,
  output logic            wd_disable_o,
  output logic [5:0]      challenge_o,
  output logic [11:0]     monitor_route_o,
  output logic            monitor_valid_o
);
  // ********************************
  // Register state
  // ********************************
  logic [7:0]     challenge_r, challenge_nxt;
  // Write-only key word: kept, never returned on reads
  logic [7:0]     key_r, key_nxt;
  logic [7:0]     monsel_r, monsel_nxt;
  logic [7:0]     res_main_r, res_main_nxt;
  logic [7:0]     res_sensor_r, res_sensor_nxt;
  logic [7:0]     rdata_r, rdata_nxt;
  wks_key_state_t key_st_r, key_st_nxt;
  logic           flash_r, flash_nxt;
  logic           config_r, config_nxt;
  logic           restart_r, restart_nxt;
  logic           disable_r, disable_nxt;
  logic [11:0]    route_r, route_nxt;
  logic           mvalid_r, mvalid_nxt;
  logic           wr_chal, wr_key, wr_mon, wr_main, wr_sens;

  assign wr_chal = bus.wr && bus.addr == `WKS_OFS_CHALLENGE;
  assign wr_key  = bus.wr && bus.addr == `WKS_OFS_KEY;
  assign wr_mon  = bus.wr && bus.addr == `WKS_OFS_MONSEL;
  assign wr_main = bus.wr && bus.addr == `WKS_OFS_RES_MAIN;
  assign wr_sens = bus.wr && bus.addr == `WKS_OFS_RES_SENSOR;

  // ********************************
  // Writable registers and flags
  // ********************************
  always_comb begin
    challenge_nxt = challenge_r;
    monsel_nxt    = monsel_r;
    key_nxt       = key_r;
    if (wr_chal) begin
      challenge_nxt = bus.wdata & `WKS_CHALLENGE_MASK;
    end
    if (wr_mon) begin
      monsel_nxt = bus.wdata & `WKS_MONSEL_MASK;
    end
    if (wr_key) begin
      key_nxt = bus.wdata;
    end
    // Set wins over clear so a failure in the clearing cycle survives
    res_main_nxt = res_main_r;
    if (wr_main) begin
      res_main_nxt = res_main_r & ~bus.wdata;
    end
    res_main_nxt = res_main_nxt | main_fail_i;
    res_sensor_nxt = res_sensor_r;
    if (wr_sens) begin
      res_sensor_nxt = res_sensor_r & ~bus.wdata;
    end
    res_sensor_nxt = (res_sensor_nxt | {4'h0, sensor_fail_i}) & `WKS_SENSOR_MASK;
  end

  // ********************************
  // Unlock key sequencer
  // ********************************
  always_comb begin
    key_st_nxt  = key_st_r;
    flash_nxt   = 1'b0;
    config_nxt  = 1'b0;
    restart_nxt = 1'b0;
    disable_nxt = disable_r;
    if (wr_key) begin
      case (key_st_r)
        WKS_KEY_IDLE: begin
          // A wrong first word simply keeps waiting
          key_st_nxt = (bus.wdata == `WKS_KEY_FIRST) ? WKS_KEY_FIRST : WKS_KEY_IDLE;
        end
        WKS_KEY_FIRST: begin
          // A repeated first word also drops back to idle
          key_st_nxt = (bus.wdata == `WKS_KEY_SECOND) ? WKS_KEY_SECOND : WKS_KEY_IDLE;
        end
        WKS_KEY_SECOND: begin
          key_st_nxt = WKS_KEY_IDLE;
          case (bus.wdata)
            `WKS_ACT_FLASH:      flash_nxt   = 1'b1;
            `WKS_ACT_CONFIG:     config_nxt  = 1'b1;
            `WKS_ACT_WD_RESTART: begin
              restart_nxt = 1'b1;
              // Restart also lifts a debug disable
              disable_nxt = 1'b0;
            end
            `WKS_ACT_WD_DISABLE: disable_nxt = 1'b1;
            default:             key_st_nxt  = WKS_KEY_IDLE;
          endcase
        end
        default: key_st_nxt = WKS_KEY_IDLE;
      endcase
    end
  end

  // ********************************
  // Monitor route and read path
  // ********************************
  always_comb begin
    route_nxt  = 12'h000;
    mvalid_nxt = 1'b0;
    // Codes past the last source drive an all-zero route and clear valid
    if (monsel_r[3:0] <= `WKS_MON_LAST_CODE) begin
      route_nxt[monsel_r[3:0]] = 1'b1;
      mvalid_nxt               = 1'b1;
    end else begin
      mvalid_nxt = 1'b0;
    end
    rdata_nxt = `WKS_RESET_VAL;
    if (bus.rd) begin
      if (bus.addr == `WKS_OFS_CHALLENGE) begin
        rdata_nxt = challenge_r;
      end else if (bus.addr == `WKS_OFS_MONSEL) begin
        rdata_nxt = monsel_r;
      end else if (bus.addr == `WKS_OFS_RES_MAIN) begin
        rdata_nxt = res_main_r;
      end else if (bus.addr == `WKS_OFS_RES_SENSOR) begin
        rdata_nxt = res_sensor_r;
      end else begin
        // Key and unmapped offsets read as zero
        rdata_nxt = `WKS_RESET_VAL;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      challenge_r  <= `WKS_RESET_VAL;
      key_r        <= `WKS_RESET_VAL;
      monsel_r     <= `WKS_RESET_VAL;
      res_main_r   <= `WKS_RESET_VAL;
      res_sensor_r <= `WKS_RESET_VAL;
      rdata_r      <= `WKS_RESET_VAL;
      key_st_r     <= WKS_KEY_IDLE;
      flash_r      <= 1'b0;
      config_r     <= 1'b0;
      restart_r    <= 1'b0;
      disable_r    <= 1'b0;
      route_r      <= 12'h000;
      mvalid_r     <= 1'b0;
    end else begin
      challenge_r  <= challenge_nxt;
      key_r        <= key_nxt;
      monsel_r     <= monsel_nxt;
      res_main_r   <= res_main_nxt;
      res_sensor_r <= res_sensor_nxt;
      rdata_r      <= rdata_nxt;
      key_st_r     <= key_st_nxt;
      flash_r      <= flash_nxt;
      config_r     <= config_nxt;
      restart_r    <= restart_nxt;
      disable_r    <= disable_nxt;
      route_r      <= route_nxt;
      mvalid_r     <= mvalid_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  // All straight from registers, so no decode glitch reaches a pin
  assign bus.rdata       = rdata_r;
  assign flash_mode_o    = flash_r;
  assign config_mode_o   = config_r;
  assign wd_restart_o    = restart_r;
  assign wd_disable_o    = disable_r;
  assign challenge_o     = challenge_r[5:0];
  assign monitor_route_o = route_r;
  assign monitor_valid_o = mvalid_r;
endmodule

// ==== rtl/wks_consts.svh ====
/*
  Constants for the watchdog key, monitor select and self-test register bank.
  Assumes inclusion by the package and both ends.
*/
`ifndef WKS_CONSTS_SVH
`define WKS_CONSTS_SVH
`define WKS_ADDR_W          5
`define WKS_DATA_W          8
`define WKS_OFS_CHALLENGE   5'h0A
`define WKS_OFS_KEY         5'h0B
`define WKS_OFS_MONSEL      5'h0C
`define WKS_OFS_RES_MAIN    5'h0D
`define WKS_OFS_RES_SENSOR  5'h0E
`define WKS_RESET_VAL       8'h00
`define WKS_CHALLENGE_MASK  8'h3F
`define WKS_MONSEL_MASK     8'h0F
`define WKS_SENSOR_MASK     8'h0F
`define WKS_KEY_FIRST       8'hD3
`define WKS_KEY_SECOND      8'h33
`define WKS_ACT_FLASH       8'hCC
`define WKS_ACT_CONFIG      8'hCD
`define WKS_ACT_WD_RESTART  8'hCE
`define WKS_ACT_WD_DISABLE  8'hCF
`define WKS_MON_LAST_CODE   4'hB
`define WKS_THERMAL_BIT     6
`define WKS_HOST_OFS_STATUS 2'h0
`define WKS_HOST_OFS_ADDR   2'h1
`define WKS_HOST_OFS_DATA   2'h2
`define WKS_HOST_OFS_RDATA  2'h3
`endif

// ==== rtl/wks_pkg.sv ====
/*
  Types for the watchdog key register bank.
  Assumes wks_consts.svh on the include path.
*/
`include "wks_consts.svh"
package wks_pkg;
  typedef enum logic [1:0] {
    WKS_KEY_IDLE   = 2'b00,
    WKS_KEY_FIRST  = 2'b01,
    WKS_KEY_SECOND = 2'b10
  } wks_key_state_t;
  typedef enum logic [1:0] {
    WKS_HOST_IDLE = 2'b00,
    WKS_HOST_WAIT = 2'b01
  } wks_host_state_t;
endpackage

// ==== rtl/wks_if.sv ====
/*
  Register access link between host and device ends.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "wks_consts.svh"
interface wks_if;
  logic [`WKS_ADDR_W-1:0] addr;
  logic [`WKS_DATA_W-1:0] wdata;
  logic                   wr;
  logic                   rd;
  logic [`WKS_DATA_W-1:0] rdata;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ==== rtl/wks_host.sv ====
/*
  Host end: turns software register accesses into link accesses.
  Assumes software on the plain port; read data one cycle after the strobe.
*/
`timescale 1ns/1ps
`include "wks_consts.svh"
module wks_host
  import wks_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sw_addr_i,
  input  wire logic [7:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic [7:0]      sw_rdata_o,
  wks_if.host             bus
);
  // ********************************
  // Command registers
  // ********************************
  // Software sets target address, then writes data (link write) or status
  // bit 0 (link read); key words must be sent in order D3, 33, action.
  logic [4:0]      tgt_r, tgt_nxt;
  logic [7:0]      wdata_r, wdata_nxt;
  logic            wr_r, wr_nxt;
  logic            rd_r, rd_nxt;
  logic [7:0]      rbuf_r, rbuf_nxt;
  logic [7:0]      sw_rdata_r, sw_rdata_nxt;
  wks_host_state_t st_r, st_nxt;

  always_comb begin
    tgt_nxt   = tgt_r;
    wdata_nxt = wdata_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    rbuf_nxt  = rbuf_r;
    st_nxt    = st_r;
    case (st_r)
      WKS_HOST_WAIT: begin
        // Link read data stands one cycle after the strobe
        rbuf_nxt = bus.rdata;
        st_nxt   = WKS_HOST_IDLE;
      end
      default: st_nxt = WKS_HOST_IDLE;
    endcase
    if (sw_wr_i) begin
      if (sw_addr_i == `WKS_HOST_OFS_ADDR) begin
        tgt_nxt = sw_wdata_i[4:0];
      end else if (sw_addr_i == `WKS_HOST_OFS_DATA) begin
        wdata_nxt = sw_wdata_i;
        wr_nxt    = 1'b1;
      end else if (sw_addr_i == `WKS_HOST_OFS_STATUS && sw_wdata_i[0]) begin
        rd_nxt = 1'b1;
      end
    end
    if (rd_r) begin
      st_nxt = WKS_HOST_WAIT;
    end
    sw_rdata_nxt = `WKS_RESET_VAL;
    if (sw_rd_i) begin
      if (sw_addr_i == `WKS_HOST_OFS_ADDR) begin
        sw_rdata_nxt = {3'b000, tgt_r};
      end else if (sw_addr_i == `WKS_HOST_OFS_DATA) begin
        sw_rdata_nxt = wdata_r;
      end else if (sw_addr_i == `WKS_HOST_OFS_RDATA) begin
        sw_rdata_nxt = rbuf_r;
      end else begin
        sw_rdata_nxt = {7'h00, st_r != WKS_HOST_IDLE || rd_r};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_r      <= 5'h00;
      wdata_r    <= `WKS_RESET_VAL;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      rbuf_r     <= `WKS_RESET_VAL;
      sw_rdata_r <= `WKS_RESET_VAL;
      st_r       <= WKS_HOST_IDLE;
    end else begin
      tgt_r      <= tgt_nxt;
      wdata_r    <= wdata_nxt;
      wr_r       <= wr_nxt;
      rd_r       <= rd_nxt;
      rbuf_r     <= rbuf_nxt;
      sw_rdata_r <= sw_rdata_nxt;
      st_r       <= st_nxt;
    end
  end

  assign bus.addr   = tgt_r;
  assign bus.wdata  = wdata_r;
  assign bus.wr     = wr_r;
  assign bus.rd     = rd_r;
  assign sw_rdata_o = sw_rdata_r;
endmodule

// ==== testbench/wks_checker.sv ====
/*
  Assertions on the register link and the device action outputs.
  Assumes one instance beside the link in the bench top.
*/
`timescale 1ns/1ps
`include "wks_consts.svh"
module wks_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        flash_mode_o,
  input wire logic        wd_restart_o,
  input wire logic        wd_disable_o,
  input wire logic [11:0] monitor_route_o,
  input wire logic        monitor_valid_o
);
  // ****************************************
  // Link and action checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_idle_read_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not zero without a read");
  a_key_reads_zero: assert property (rd && addr == `WKS_OFS_KEY |=> rdata == 8'h00)
    else $error("key register readable");
  a_challenge_upper_zero: assert property (rd && addr == `WKS_OFS_CHALLENGE |=> rdata[7:6] == 2'h0)
    else $error("challenge upper bits set");
  a_flash_after_key: assert property (flash_mode_o |-> $past(wr && addr == `WKS_OFS_KEY && wdata == `WKS_ACT_FLASH))
    else $error("flash pulse without action word");
  a_restart_after_key: assert property (wd_restart_o |-> $past(wr && addr == `WKS_OFS_KEY && wdata == `WKS_ACT_WD_RESTART))
    else $error("restart pulse without action word");
  a_restart_single_pulse: assert property (wd_restart_o |=> !wd_restart_o)
    else $error("restart pulse too long");
  a_disable_after_key: assert property ($rose(wd_disable_o) |-> $past(wr && addr == `WKS_OFS_KEY && wdata == `WKS_ACT_WD_DISABLE))
    else $error("disable without action word");
  // Route lags the select register by one more cycle
  a_route_follows_select: assert property (wr && addr == `WKS_OFS_MONSEL |-> ##2
    ($past(wdata[3:0], 2) > 4'hB ? !monitor_valid_o && monitor_route_o == 12'h000
                                 : monitor_route_o == 12'h001 << $past(wdata[3:0], 2)))
    else $error("monitor route wrong");
  c_restart: cover property (wd_restart_o);
  c_disable: cover property ($rose(wd_disable_o));
  c_thermal: cover property (rd && addr == `WKS_OFS_RES_MAIN ##1 rdata[6]);
endmodule

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench: host and device joined by the link.
  Assumes software accesses go only through the host's plain port.
*/
`timescale 1ns/1ps
`include "wks_consts.svh"
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  sw_addr = 2'h0;
  logic [7:0]  sw_wdata = 8'h00;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [7:0]  sw_rdata, d;
  logic [7:0]  main_fail = 8'h00;
  logic [3:0]  sensor_fail = 4'h0;
  logic        flash, cfg, restart, wd_off, valid;
  logic [5:0]  challenge;
  logic [11:0] route;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          act_cnt [3] = '{0, 0, 0};
  int          exp_cnt [3] = '{0, 0, 0};
  logic [4:0]  ofs [6] = '{`WKS_OFS_CHALLENGE, `WKS_OFS_KEY, `WKS_OFS_MONSEL,
                          `WKS_OFS_RES_MAIN, `WKS_OFS_RES_SENSOR, 5'h1F};
  logic [7:0]  acts [4] = '{`WKS_ACT_FLASH, `WKS_ACT_CONFIG, `WKS_ACT_WD_DISABLE, `WKS_ACT_WD_RESTART};
  logic [7:0]  bad [3][3] = '{'{8'hD3, 8'h34, 8'h33}, '{8'hD3, 8'h33, 8'h00}, '{8'hD3, 8'hD3, 8'h33}};
  wks_if link ();
  wks_host u_wks_host (.clk_i(clk_i), .rst_i(rst_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .bus(link));
  wks_device u_wks_device (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .main_fail_i(main_fail),
    .sensor_fail_i(sensor_fail), .flash_mode_o(flash), .config_mode_o(cfg), .wd_restart_o(restart),
    .wd_disable_o(wd_off), .challenge_o(challenge), .monitor_route_o(route), .monitor_valid_o(valid));
  wks_checker u_wks_checker (.clk_i(clk_i), .rst_i(rst_i), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .flash_mode_o(flash), .wd_restart_o(restart),
    .wd_disable_o(wd_off), .monitor_route_o(route), .monitor_valid_o(valid));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    act_cnt[0] <= act_cnt[0] + int'(flash);
    act_cnt[1] <= act_cnt[1] + int'(cfg);
    act_cnt[2] <= act_cnt[2] + int'(restart);
  end
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic sw_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge clk_i);
    sw_wr    <= 1'b0;
  endtask
  task automatic sw_read(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk_i);
    sw_rd   <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task automatic dev_write(input logic [4:0] a, input logic [7:0] v);
    sw_write(`WKS_HOST_OFS_ADDR, {3'h0, a});
    sw_write(`WKS_HOST_OFS_DATA, v);
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic dev_read(input logic [4:0] a, output logic [7:0] v);
    int i;
    sw_write(`WKS_HOST_OFS_ADDR, {3'h0, a});
    sw_write(`WKS_HOST_OFS_STATUS, 8'h01);
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      sw_read(`WKS_HOST_OFS_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 8) begin
      error_cnt++;
      $display("FAIL time %0t busy got %0h exp %0h", $time, v, 8'h00);
      close_out();
    end else begin
      sw_read(`WKS_HOST_OFS_RDATA, v);
    end
  endtask
  task automatic send_key(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3);
    dev_write(`WKS_OFS_KEY, w1);
    dev_write(`WKS_OFS_KEY, w2);
    dev_write(`WKS_OFS_KEY, w3);
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL time %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[k]) begin
      dev_read(ofs[k], d);
      chk(d, 12'h000);
    end
    $display("test reset done");
    dev_write(`WKS_OFS_CHALLENGE, 8'hFF);
    dev_read(`WKS_OFS_CHALLENGE, d);
    chk(d, 12'h03F);
    chk(challenge, 12'h03F);
    sw_read(`WKS_HOST_OFS_ADDR, d);
    chk(d, 12'(`WKS_OFS_CHALLENGE));
    sw_read(`WKS_HOST_OFS_DATA, d);
    chk(d, 12'h0FF);
    for (int c = 0; c < 16; c++) begin
      dev_write(`WKS_OFS_MONSEL, 8'hF0 | 8'(c));
      dev_read(`WKS_OFS_MONSEL, d);
      chk(d, 12'(c));
      chk(route, c < 12 ? 12'h001 << c : 12'h000);
      chk(valid, c < 12);
    end
    $display("test monitor done");
    for (int a = 0; a < 4; a++) begin
      send_key(`WKS_KEY_FIRST, `WKS_KEY_SECOND, acts[a]);
      if (a != 2) exp_cnt[a == 3 ? 2 : a]++;
      for (int j = 0; j < 3; j++) chk(act_cnt[j], exp_cnt[j]);
      chk(wd_off, a == 2);
    end
    dev_read(`WKS_OFS_KEY, d);
    chk(d, 12'h000);
    for (int b = 0; b < 3; b++) begin
      send_key(bad[b][0], bad[b][1], bad[b][2]);
      dev_write(`WKS_OFS_KEY, `WKS_ACT_WD_RESTART);
      chk(act_cnt[2], exp_cnt[2]);
    end
    send_key(`WKS_KEY_FIRST, `WKS_KEY_SECOND, `WKS_ACT_WD_RESTART);
    chk(act_cnt[2], exp_cnt[2] + 1);
    $display("test key done");
    @(posedge clk_i);
    main_fail   <= 8'hC1;
    sensor_fail <= 4'h9;
    @(posedge clk_i);
    main_fail   <= 8'h00;
    sensor_fail <= 4'h0;
    dev_read(`WKS_OFS_RES_MAIN, d);
    chk(d, 12'h0C1);
    dev_write(`WKS_OFS_RES_MAIN, 8'hBF);
    dev_read(`WKS_OFS_RES_MAIN, d);
    chk(d, 12'h040);
    dev_write(`WKS_OFS_RES_MAIN, 8'h40);
    dev_read(`WKS_OFS_RES_MAIN, d);
    chk(d, 12'h000);
    dev_write(`WKS_OFS_RES_SENSOR, 8'hF1);
    dev_read(`WKS_OFS_RES_SENSOR, d);
    chk(d, 12'h008);
    $display("test selftest done");
    close_out();
  end
endmodule
